/* design/adcc_clkdiv.sv */
`timescale 1ns/10ps
`default_nettype none

module adcc_clkdiv #(
  parameter int DIVW = 7
) (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Control.
  input  wire logic [2:0]      div_sel,
  input  wire logic            restart,
  // Converter clock tick.
  output logic                 tick
);

  logic [DIVW-1:0] count_q;
  logic [DIVW-1:0] mask;

  initial begin
    if (DIVW < 7) $error("adcc_clkdiv: DIVW must be at least 7");
  end

  // ****************************************************
  // Divider, one tick per 2**div_sel cycles.
  // ****************************************************
  assign mask = DIVW'((8'h01 << div_sel) - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (restart) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= !restart && ((count_q & mask) == mask);
    end
  end

endmodule : adcc_clkdiv

`default_nettype wire

/* design/adcc_ctrl.sv */
`include "adcc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module adcc_ctrl #(
  parameter int PINS = 8,
  parameter int RESW = 12
) (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Analog comparator.
  input  wire logic                 cmp_in,
  // Pin-shared function state.
  input  wire logic [PINS-1:0]      pin_analog_sel,
  input  wire logic [PINS-1:0]      gpio_oe_n,
  input  wire logic [PINS-1:0]      gpio_pull_en,
  output logic [PINS-1:0]           pin_oe_n,
  output logic [PINS-1:0]           pin_pull_en,
  output logic [PINS-1:0]           pin_dig_in_en,
  // Analog front-end controls.
  output logic                      conv_power_en,
  output logic                      sample_en,
  output logic [RESW-1:0]           dac_code,
  output logic [PINS-1:0]           ext_channel_on,
  output adcc_pkg::adcc_route_t     input_route,
  output adcc_pkg::adcc_ref_t       ref_route,
  output logic                      ref_pin_on,
  output logic                      amp_enable,
  output logic [1:0]                amp_gain_sel,
  output logic                      amp_ref_input_pin_on,
  output logic                      bandgap_voltage_on,
  output logic                      bandgap_enable,
  // Completion request.
  output logic                      conv_done
);
  import adcc_pkg::*;

  initial begin
    if (RESW != 12) $error("adcc_ctrl: RESW must be 12");
    if (PINS != 8) $error("adcc_ctrl: PINS must be 8");
  end

  // ****************************************************
  // Decoding helpers.
  // ****************************************************
  function automatic adcc_route_t route_of(input logic [3:0] s);
    unique case (s[3:2])
      2'b11:   route_of = RT_EXT;
      2'b10:   route_of = RT_GND;
      2'b01:   route_of = (s[1:0] == 2'b00) ? RT_EXT : adcc_route_t'({1'b1, s[1:0] - 2'b01});
      default: route_of = adcc_route_t'({1'b0, s[1:0]});
    endcase
  endfunction : route_of

  function automatic adcc_ref_t ref_of(input logic [1:0] s);
    ref_of = s[1] ? REF_AMP : (s[0] ? REF_PIN : REF_SUPPLY);
  endfunction : ref_of

  // ****************************************************
  // Register state.
  // ****************************************************
  logic              start_q;
  logic              armed_q;
  logic              conv_busy_q;
  logic              conv_enable_q;
  logic              result_align_sel_q;
  logic [3:0]        ext_channel_sel_q;
  logic [3:0]        input_source_sel_q;
  logic [2:0]        conv_clock_div_sel_q;
  logic              amp_enable_q;
  logic              amp_input_sel_q;
  logic [1:0]        reference_sel_q;
  logic [1:0]        amp_gain_sel_q;
  logic              bandgap_enable_q;
  logic [RESW-1:0]   result_q;
  logic [RESW-1:0]   sar_q;
  adcc_state_t       state_q;
  logic [3:0]        cnt_q;
  logic              cmp_meta_q;
  logic              cmp_sync_q;
  logic              tick;
  logic              wr;
  logic              go;
  logic              last_tick;
  logic [RESW-1:0]   trial;
  logic [7:0]        ctl0_rd;
  logic [7:0]        res_lo_rd;
  logic [7:0]        res_hi_rd;
  adcc_route_t       route;

  assign wr = psel && penable && pready && pwrite;
  assign route = route_of(input_source_sel_q);

  // ****************************************************
  // APB access timing: one wait-free access phase.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(paddr inside {`ADCC_OFF_CTL0, `ADCC_OFF_CTL1, `ADCC_OFF_CTL2,
                                 `ADCC_OFF_BGAP, `ADCC_OFF_RES_LO, `ADCC_OFF_RES_HI});
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ****************************************************
  // Read path.
  // ****************************************************
  assign ctl0_rd = {start_q, conv_busy_q, conv_enable_q, result_align_sel_q, ext_channel_sel_q};
  assign res_hi_rd = result_align_sel_q ? {4'h0, result_q[11:8]} : result_q[11:4];
  assign res_lo_rd = result_align_sel_q ? result_q[7:0] : {result_q[3:0], 4'h0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `ADCC_OFF_CTL0:   prdata <= {24'h00_0000, ctl0_rd};
        `ADCC_OFF_CTL1:   prdata <= {24'h00_0000, input_source_sel_q, 1'b0, conv_clock_div_sel_q};
        `ADCC_OFF_CTL2:   prdata <= {24'h00_0000, amp_enable_q, 2'b00, amp_input_sel_q,
                                     reference_sel_q, amp_gain_sel_q};
        `ADCC_OFF_BGAP:   prdata <= {31'h0000_0000, bandgap_enable_q};
        `ADCC_OFF_RES_LO: prdata <= {24'h00_0000, res_lo_rd};
        `ADCC_OFF_RES_HI: prdata <= {24'h00_0000, res_hi_rd};
        default:          prdata <= 32'h0000_0000;
      endcase
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // ****************************************************
  // Software-written control fields.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {start_q, conv_enable_q, result_align_sel_q, ext_channel_sel_q} <= 7'h00;
    end else if (wr && paddr == `ADCC_OFF_CTL0) begin
      start_q            <= pwdata[`ADCC_C0_START];
      conv_enable_q      <= pwdata[`ADCC_C0_EN];
      result_align_sel_q <= pwdata[`ADCC_C0_ALIGN];
      ext_channel_sel_q  <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {input_source_sel_q, conv_clock_div_sel_q} <= 7'h00;
    end else if (wr && paddr == `ADCC_OFF_CTL1) begin
      input_source_sel_q   <= pwdata[`ADCC_C1_SRC_LSB +: 4];
      conv_clock_div_sel_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {amp_enable_q, amp_input_sel_q, reference_sel_q, amp_gain_sel_q} <= 6'h00;
    end else if (wr && paddr == `ADCC_OFF_CTL2) begin
      amp_enable_q    <= pwdata[`ADCC_C2_AMP_EN];
      amp_input_sel_q <= pwdata[`ADCC_C2_AMP_IN];
      reference_sel_q <= pwdata[`ADCC_C2_REF_LSB +: 2];
      amp_gain_sel_q  <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bandgap_enable_q <= 1'b0;
    end else if (wr && paddr == `ADCC_OFF_BGAP) begin
      bandgap_enable_q <= pwdata[`ADCC_BG_EN];
    end
  end

  // ****************************************************
  // Start sequence detection.
  // ****************************************************
  // A rising write arms; the following falling write fires.
  // The enable must already stand, or busy would be set with no running sequencer to clear it.
  assign go = wr && paddr == `ADCC_OFF_CTL0 && armed_q && !pwdata[`ADCC_C0_START]
              && pwdata[`ADCC_C0_EN] && conv_enable_q && state_q == ST_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (wr && paddr == `ADCC_OFF_CTL0) begin
      armed_q <= !start_q && pwdata[`ADCC_C0_START] || armed_q && pwdata[`ADCC_C0_START];
    end
  end

  // ****************************************************
  // Converter clock and comparator synchroniser.
  // ****************************************************
  adcc_clkdiv #(
    .DIVW (7)
  ) u_clkdiv (
    .pclk    (pclk),
    .presetn (presetn),
    .div_sel (conv_clock_div_sel_q),
    .restart (go),
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ****************************************************
  // Conversion sequencer.
  // ****************************************************
  assign last_tick = tick && cnt_q == 4'h1;
  assign trial = sar_q | (RESW'(1) << cnt_q[3:0] - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
    end else if (!conv_enable_q) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_SAMPLE;
            cnt_q   <= `ADCC_SAMPLE_TICKS;
          end
        end
        ST_SAMPLE: begin
          if (last_tick) begin
            state_q <= ST_CONVERT;
            cnt_q   <= `ADCC_CONV_TICKS;
          end else if (tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_CONVERT: begin
          if (last_tick) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
          end else if (tick) begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // Bit cnt-1 is tried during each conversion period and kept on a high comparator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q <= '0;
    end else if (go) begin
      sar_q <= '0;
    end else if (state_q == ST_CONVERT && tick) begin
      sar_q <= cmp_sync_q ? trial : sar_q;
    end
  end

  // Busy is hardware owned; writes to its position never reach it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy_q <= 1'b0;
    end else if (go) begin
      conv_busy_q <= 1'b1;
    end else if (!conv_enable_q || state_q == ST_CONVERT && last_tick) begin
      conv_busy_q <= 1'b0;
    end
  end

  // Results move only on a finished conversion, so disabling leaves them intact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (conv_enable_q && state_q == ST_CONVERT && last_tick) begin
      result_q <= cmp_sync_q ? trial : sar_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done <= 1'b0;
    end else begin
      conv_done <= conv_enable_q && state_q == ST_CONVERT && last_tick;
    end
  end

  // ****************************************************
  // Analog routing outputs.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_en  <= 1'b0;
      sample_en      <= 1'b0;
      dac_code       <= '0;
      ext_channel_on <= '0;
      input_route    <= RT_EXT;
    end else begin
      conv_power_en <= conv_enable_q;
      sample_en     <= state_q == ST_SAMPLE;
      dac_code      <= state_q == ST_CONVERT ? trial : '0;
      input_route   <= route;
      // The channel switch closes only for an external route and a code below eight.
      ext_channel_on <= (conv_enable_q && route == RT_EXT && !ext_channel_sel_q[3])
                        ? PINS'(8'h01 << ext_channel_sel_q[2:0]) : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_route            <= REF_SUPPLY;
      ref_pin_on           <= 1'b0;
      amp_enable           <= 1'b0;
      amp_gain_sel         <= 2'b00;
      amp_ref_input_pin_on <= 1'b0;
      bandgap_voltage_on   <= 1'b0;
      bandgap_enable       <= 1'b0;
    end else begin
      ref_route  <= ref_of(reference_sel_q);
      ref_pin_on <= ref_of(reference_sel_q) == REF_PIN;
      // Software keeps the amplifier on while it is used; it is not forced here.
      amp_enable           <= amp_enable_q;
      amp_gain_sel         <= amp_gain_sel_q;
      amp_ref_input_pin_on <= !amp_input_sel_q;
      bandgap_voltage_on   <= amp_input_sel_q;
      bandgap_enable       <= bandgap_enable_q;
    end
  end

  // ****************************************************
  // Pin-shared function override.
  // ****************************************************
  adcc_pinmux #(
    .PINS (PINS)
  ) u_pinmux (
    .pclk           (pclk),
    .presetn        (presetn),
    .pin_analog_sel (pin_analog_sel),
    .gpio_oe_n      (gpio_oe_n),
    .gpio_pull_en   (gpio_pull_en),
    .pin_oe_n       (pin_oe_n),
    .pin_pull_en    (pin_pull_en),
    .pin_dig_in_en  (pin_dig_in_en)
  );

endmodule : adcc_ctrl

`default_nettype wire

/* design/adcc_pinmux.sv */
`timescale 1ns/10ps
`default_nettype none

module adcc_pinmux #(
  parameter int PINS = 8
) (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Pin-shared function state.
  input  wire logic [PINS-1:0] pin_analog_sel,
  input  wire logic [PINS-1:0] gpio_oe_n,
  input  wire logic [PINS-1:0] gpio_pull_en,
  // Resolved pin controls.
  output logic [PINS-1:0]      pin_oe_n,
  output logic [PINS-1:0]      pin_pull_en,
  output logic [PINS-1:0]      pin_dig_in_en
);

  initial begin
    if (PINS < 1) $error("adcc_pinmux: PINS must be positive");
  end

  // ****************************************************
  // Analog selection overrides every digital use.
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_n      <= '1;
      pin_pull_en   <= '0;
      pin_dig_in_en <= '0;
    end else begin
      pin_oe_n      <= gpio_oe_n | pin_analog_sel;
      pin_pull_en   <= gpio_pull_en & ~pin_analog_sel;
      pin_dig_in_en <= ~pin_analog_sel;
    end
  end

endmodule : adcc_pinmux

`default_nettype wire

/* design/adcc_pkg.sv */
package adcc_pkg;

  // Converter input routing.
  typedef enum logic [2:0] {
    RT_EXT, RT_VDD, RT_VDD_2, RT_VDD_4,
    RT_AMP, RT_AMP_2, RT_AMP_4, RT_GND
  } adcc_route_t;

  // Converter reference routing.
  typedef enum logic [1:0] {
    REF_SUPPLY, REF_PIN, REF_AMP
  } adcc_ref_t;

  // Conversion sequencer.
  typedef enum logic [1:0] {
    ST_IDLE, ST_SAMPLE, ST_CONVERT
  } adcc_state_t;

endpackage : adcc_pkg

/* design/adcc_regs.svh */
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ****************************************************
// Register byte offsets.
// ****************************************************
`define ADCC_OFF_CTL0      8'h00
`define ADCC_OFF_CTL1      8'h04
`define ADCC_OFF_CTL2      8'h08
`define ADCC_OFF_BGAP      8'h0c
`define ADCC_OFF_RES_LO    8'h10
`define ADCC_OFF_RES_HI    8'h14

// ****************************************************
// Field positions.
// ****************************************************
`define ADCC_C0_START      7
`define ADCC_C0_BUSY       6
`define ADCC_C0_EN         5
`define ADCC_C0_ALIGN      4
`define ADCC_C1_SRC_LSB    4
`define ADCC_C2_AMP_EN     7
`define ADCC_C2_AMP_IN     4
`define ADCC_C2_REF_LSB    2
`define ADCC_BG_EN         0

// ****************************************************
// Reset values and timing counts.
// ****************************************************
`define ADCC_RST_CTL       8'h00
`define ADCC_SAMPLE_TICKS  4'h4
`define ADCC_CONV_TICKS    4'hc

`endif

/* verif/adcc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module adcc_monitor
  import adcc_pkg::*;
#(
  parameter int PINS = 8,
  parameter int RESW = 12
) (
  // Clock, reset and bus.
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Pins.
  input wire logic [PINS-1:0] pin_analog_sel,
  input wire logic [PINS-1:0] gpio_oe_n,
  input wire logic [PINS-1:0] gpio_pull_en,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic [PINS-1:0] pin_pull_en,
  input wire logic [PINS-1:0] pin_dig_in_en,
  // Converter.
  input wire logic            sample_en,
  input wire logic            conv_power_en,
  input wire logic            conv_done,
  input wire logic [PINS-1:0] ext_channel_on,
  input wire adcc_route_t     input_route,
  input wire logic            amp_ref_input_pin_on,
  input wire logic            bandgap_voltage_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_sample_start;
    $rose(sample_en);
  endsequence

  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_unmapped;
    s_setup ##0 (paddr > 8'h14) |=> pslverr && prdata == 32'h0;
  endproperty
  // The first edge after reset still sees reset values, so it is skipped.
  property p_pin_dir;
    $past(presetn) |-> pin_oe_n == $past(gpio_oe_n | pin_analog_sel);
  endproperty
  property p_pin_pull;
    $past(presetn) |-> pin_pull_en == $past(gpio_pull_en & ~pin_analog_sel) && pin_dig_in_en == ~$past(pin_analog_sel);
  endproperty
  property p_done_pulse;
    conv_done |=> !conv_done;
  endproperty
  property p_onehot;
    $onehot0(ext_channel_on);
  endproperty
  property p_internal;
    input_route != RT_EXT |-> ext_channel_on == '0;
  endproperty
  property p_amp_input;
    $past(presetn) |-> amp_ref_input_pin_on != bandgap_voltage_on;
  endproperty
  property p_sample_len;
    s_sample_start |-> sample_en [*4];
  endproperty
  property p_convert_len;
    $fell(sample_en) && conv_power_en |-> !conv_done [*8];
  endproperty

  a_ready: assert property (p_ready) else $error("ready is not one access cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction not overridden");
  a_pin_pull: assert property (p_pin_pull) else $error("analog pin keeps pull or input");
  a_done_pulse: assert property (p_done_pulse) else $error("done is not a pulse");
  a_onehot: assert property (p_onehot) else $error("several channels on");
  a_internal: assert property (p_internal) else $error("channel on with internal source");
  a_amp_input: assert property (p_amp_input) else $error("amplifier inputs not exclusive");
  a_sample_len: assert property (p_sample_len) else $error("sampling too short");
  a_convert_len: assert property (p_convert_len) else $error("conversion too short");
endmodule : adcc_monitor

bind adcc_ctrl adcc_monitor #(.PINS(PINS), .RESW(RESW)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_analog_sel(pin_analog_sel),
  .gpio_oe_n(gpio_oe_n), .gpio_pull_en(gpio_pull_en), .pin_oe_n(pin_oe_n),
  .pin_pull_en(pin_pull_en), .pin_dig_in_en(pin_dig_in_en), .sample_en(sample_en),
  .conv_power_en(conv_power_en), .conv_done(conv_done), .ext_channel_on(ext_channel_on),
  .input_route(input_route), .amp_ref_input_pin_on(amp_ref_input_pin_on),
  .bandgap_voltage_on(bandgap_voltage_on)
);

`default_nettype wire

/* verif/testbench.sv */
`include "adcc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import adcc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cmp_in = 0, re;
  logic [7:0]  paddr = 0, pin_analog_sel = 0, gpio_oe_n = 8'hff, gpio_pull_en = 0, v;
  logic [31:0] pwdata = 0, rq, prdata;
  logic        pready, pslverr, conv_power_en, sample_en, ref_pin_on, amp_enable, conv_done;
  logic        amp_ref_input_pin_on, bandgap_voltage_on, bandgap_enable, cm;
  logic [11:0] dac_code;
  logic [7:0]  pin_oe_n, pin_pull_en, pin_dig_in_en, ext_channel_on;
  logic [1:0]  amp_gain_sel;
  adcc_route_t input_route;
  adcc_ref_t   ref_route;
  int          mismatches = 0, cmp_count = 0, done_cnt = 0, cyc = 0, seed = 32'he5de, s, c, t0, base;

  adcc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmp_in, .pin_analog_sel, .gpio_oe_n, .gpio_pull_en, .pin_oe_n, .pin_pull_en,
    .pin_dig_in_en, .conv_power_en, .sample_en, .dac_code, .ext_channel_on, .input_route,
    .ref_route, .ref_pin_on, .amp_enable, .amp_gain_sel, .amp_ref_input_pin_on,
    .bandgap_voltage_on, .bandgap_enable, .conv_done);

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conv_done === 1'b1) done_cnt <= done_cnt + 1;
  end

  // ****************************************
  // Checking and bus tasks.
  // ****************************************
  task automatic print_verdict;
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      mismatches++;
      print_verdict();
    end
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rq, e);
  endtask : rdc

  function automatic logic [31:0] fmt(input logic [11:0] r, input logic al, input logic hi);
    if (hi) return al ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
    return al ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
  endfunction : fmt

  function automatic adcc_route_t exp_route(input int s);
    if (s == 0 || s == 4 || s >= 12) return RT_EXT;
    if (s < 4) return adcc_route_t'(3'(s));
    if (s < 8) return adcc_route_t'(3'(s - 1));
    return RT_GND;
  endfunction : exp_route

  // Arms, starts and either aborts or waits out one conversion.
  task automatic conv(input logic [2:0] dv, input logic ab);
    int k;
    apb(1'b1, `ADCC_OFF_CTL1, {29'h0, dv});
    apb(1'b1, `ADCC_OFF_CTL0, 32'ha0);
    apb(1'b1, `ADCC_OFF_CTL0, 32'h20);
    t0 = cyc;
    rdc(`ADCC_OFF_CTL0, 32'h60);
    chk(conv_power_en, 32'h1);
    if (ab) begin
      repeat (60) @(posedge pclk);
      apb(1'b1, `ADCC_OFF_CTL0, 32'h0);
      rdc(`ADCC_OFF_CTL0, 32'h0);
      return;
    end
    for (k = 0; k < 200; k++) begin
      apb(1'b0, `ADCC_OFF_CTL0, 32'h0);
      if (rq[6] === 1'b0) break;
    end
    chk(32'(k < 200), 32'h1);
    chk(32'(cyc - t0 >= (16 << dv) && cyc - t0 <= (17 << dv) + 8), 32'h1);
    chk(dac_code, 32'h0);
  endtask : conv

  initial begin
    #2500000;
    mismatches++;
    print_verdict();
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (8) @(posedge pclk);
    chk(pin_oe_n, 32'hff);
    presetn <= 1'b1;
    for (s = 0; s < 4; s++) rdc(8'(4 * s), 32'h0);
    rdc(8'h40, 32'h0);
    chk(re, 32'h1);
    apb(1'b1, `ADCC_OFF_CTL1, 32'hff);
    rdc(`ADCC_OFF_CTL1, 32'hf7);
    apb(1'b1, `ADCC_OFF_BGAP, 32'hff);
    rdc(`ADCC_OFF_BGAP, 32'h1);
    chk(bandgap_enable, 32'h1);
    for (s = 0; s < 16; s++) begin
      c = $random(seed) & 15;
      pin_analog_sel <= 8'($random(seed));
      gpio_oe_n <= 8'($random(seed));
      gpio_pull_en <= 8'($random(seed));
      apb(1'b1, `ADCC_OFF_CTL0, 32'h20 | c);
      apb(1'b1, `ADCC_OFF_CTL1, s << 4);
      repeat (2) @(posedge pclk);
      chk(input_route, exp_route(s));
      chk(ext_channel_on, (exp_route(s) == RT_EXT && c < 8) ? 1 << c : 0);
      chk(pin_oe_n, gpio_oe_n | pin_analog_sel);
      chk(pin_pull_en, gpio_pull_en & ~pin_analog_sel);
      chk(pin_dig_in_en, 8'(~pin_analog_sel));
    end
    for (s = 0; s < 32; s++) begin
      v = 8'($random(seed) & 8'he0 | s);
      v[7] = v[7] | v[3];
      apb(1'b1, `ADCC_OFF_CTL2, v);
      rdc(`ADCC_OFF_CTL2, v & 8'h9f);
      chk(ref_route, v[3] ? 2 : v[2]);
      chk(ref_pin_on, v[3:2] == 2'b01);
      chk(amp_gain_sel, v[1:0]);
      chk(bandgap_voltage_on, v[4]);
      chk(amp_ref_input_pin_on, !v[4]);
      chk(amp_enable, v[7]);
    end
    apb(1'b1, `ADCC_OFF_CTL0, 32'h60);
    rdc(`ADCC_OFF_CTL0, 32'h20);
    cmp_in <= 1'b1;
    base = done_cnt;
    conv(3'h0, 1'b0);
    chk(done_cnt, base + 1);
    rdc(`ADCC_OFF_RES_HI, 32'hff);
    rdc(`ADCC_OFF_RES_LO, 32'hf0);
    apb(1'b1, `ADCC_OFF_CTL0, 32'h30);
    rdc(`ADCC_OFF_RES_HI, 32'h0f);
    apb(1'b1, `ADCC_OFF_RES_LO, 32'h5a);
    rdc(`ADCC_OFF_RES_LO, 32'hff);
    cmp_in <= 1'b0;
    conv(3'h3, 1'b1);
    chk(conv_power_en, 32'h0);
    rdc(`ADCC_OFF_RES_HI, 32'hff);
    apb(1'b1, `ADCC_OFF_CTL0, 32'h80);
    apb(1'b1, `ADCC_OFF_CTL0, 32'h0);
    rdc(`ADCC_OFF_CTL0, 32'h0);
    for (s = 0; s < 3; s++) begin
      cm = 1'($random(seed));
      cmp_in <= cm;
      base = done_cnt;
      conv(3'(s), 1'b0);
      chk(done_cnt, base + 1);
      rdc(`ADCC_OFF_RES_HI, fmt({12{cm}}, 1'b0, 1'b1));
      rdc(`ADCC_OFF_RES_LO, fmt({12{cm}}, 1'b0, 1'b0));
    end
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
